// *** core/fpec_ctrl.sv ***
// Behaviour
// R1: target bit 0 picks commit target: 1 program-enable, 0 read-enable.
// R2: keyed write with commit bit starts a nonvolatile save of selection.
// R3: software programs a word: data, offset, keyed write, poll write bit.
// R4: software erases a page: offset, keyed erase, poll erase bit.
// R5: software mass erases: keyed mass-erase, poll its bit.
// R6: protection bits may only be cleared by writes.
// R7: protection registers reload from nonvolatile storage after reset.
// R8: eight per-block enable bits, reset to ones, upper bits read zero.
// R9: protection changes affect access checks at once, before commit.
// R10: tick reload field is MHz minus one, divider for microsecond tick.
// R11: software reloads the tick field when the clock changes.
// R12: offset field is bits 12:0; software keeps it aligned.
// R13: data word used for program, ignored for erase.
// R14: valid command starts the cycle at the held offset with held data.
// R15: software sets exactly one operation bit per write.
// R16: commands without key 0xA442 ignored; key reads as zero.
// R17: commit bit reads one until done, up to 50 us; zero writes no-op.
// R18: controller and system-control registers decode at their own bases.
// R19: writing one to masked status clears the bit; reset zero.
// R20: erase bit up to 25 ms, mass erase up to 250 ms, read busy.
// R21: write bit programs the word, reads one until done, up to 50 us.
// R22: protected blocks refuse program, erase and data reads.
// R23: raw status flags program completion and access violations.
// R24: command writes ignored while an operation is busy.
// R25: tick reload register resets to one chosen value.
`timescale 1ns/10ps
`include "fpec_params.svh"

module fpec_ctrl
#(
  parameter int unsigned P_PROG_US   = `FPEC_PROG_US,
  parameter int unsigned P_COMMIT_US = `FPEC_COMMIT_US,
  parameter int unsigned P_ERASE_US  = `FPEC_ERASE_US,
  parameter int unsigned P_FULL_ERASE_BIT_US = `FPEC_FULL_ERASE_BIT_US
)
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset_n,
  input  wire fpec_pkg::fpec_bus_s i_bus,
  output logic              [31:0] o_rdata,
  input  wire logic          [7:0] i_nv_re,
  input  wire logic          [7:0] i_nv_pe,
  input  wire logic                i_rd_valid,
  input  wire logic         [13:0] i_rd_addr,
  output logic                     o_rd_blocked,
  output fpec_pkg::fpec_nvm_s      o_nvm,
  output logic                     o_us_tick
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] blk_of(input logic [13:0] a);
    blk_of = a[13:11];
  endfunction

  function automatic logic [17:0] us_len(input fpec_pkg::fpec_op_e k);
    unique case (k)
      fpec_pkg::op_write:  us_len = 18'(P_PROG_US);
      fpec_pkg::op_erase:  us_len = 18'(P_ERASE_US);
      fpec_pkg::op_full_erase_bit: us_len = 18'(P_FULL_ERASE_BIT_US);
      fpec_pkg::op_commit: us_len = 18'(P_COMMIT_US);
      default:             us_len = 18'h00001;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpec_pkg::fpec_state_e state;
  fpec_pkg::fpec_op_e    op;
  logic           [12:0] target;
  logic           [31:0] wdata;
  logic            [7:0] tick_reload;
  logic            [7:0] irq_mask;
  logic            [1:0] raw;
  logic           [17:0] us_left;
  logic            [7:0] re_prot;
  logic            [7:0] pe_prot;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire        in_flash  = i_bus.addr[31:12] == 20'(`FPEC_FLASH_BASE >> 12);
  wire        in_sysctl = i_bus.addr[31:12] == 20'(`FPEC_SYSCTL_BASE >> 12);
  wire [11:0] ofs       = i_bus.addr[11:0];
  // R18: two bases
  wire hit_target = in_flash  && ofs == `FPEC_OFS_TARGET;
  wire hit_wdata  = in_flash  && ofs == `FPEC_OFS_WDATA;
  wire hit_cmd    = in_flash  && ofs == `FPEC_OFS_CMD;
  wire hit_raw    = in_flash  && ofs == `FPEC_OFS_RAW;
  wire hit_mask   = in_flash  && ofs == `FPEC_OFS_MASK;
  wire hit_misc   = in_flash  && ofs == `FPEC_OFS_MISC;
  wire hit_re     = in_sysctl && ofs == `FPEC_OFS_RE_PROT;
  wire hit_pe     = in_sysctl && ofs == `FPEC_OFS_PE_PROT;
  wire hit_tick   = in_sysctl && ofs == `FPEC_OFS_TICK;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire busy      = state == fpec_pkg::st_run;
  wire cmd_wr    = i_bus.wr && hit_cmd;
  // R16: key check
  wire key_ok    = i_bus.wdata[31:16] == `FPEC_CMD_KEY;
  // R24: busy blocks new commands
  wire cmd_take  = cmd_wr && key_ok && !busy;
  wire [3:0] cbit = i_bus.wdata[3:0];

  // lowest set bit wins when several are written
  fpec_pkg::fpec_op_e req_op;
  assign req_op =
    cbit[`FPEC_CMD_WRITE]  ? fpec_pkg::op_write  :
    cbit[`FPEC_CMD_ERASE]  ? fpec_pkg::op_erase  :
    cbit[`FPEC_CMD_FULL_ERASE_BIT] ? fpec_pkg::op_full_erase_bit :
    cbit[`FPEC_CMD_COMMIT] ? fpec_pkg::op_commit :
                             fpec_pkg::op_none;

  // R9: checks use live protection values
  // R22: refuse program or erase on protected block
  wire tgt_pe_ok = pe_prot[blk_of({1'b0, target})];
  wire pe_denied =
    ((req_op == fpec_pkg::op_write || req_op == fpec_pkg::op_erase)
      && !tgt_pe_ok) ||
    (req_op == fpec_pkg::op_full_erase_bit && pe_prot != 8'hFF);
  wire start     = cmd_take && req_op != fpec_pkg::op_none && !pe_denied;
  wire cmd_viol  = cmd_take && req_op != fpec_pkg::op_none && pe_denied;

  // R22: data reads of read-protected blocks
  assign o_rd_blocked = i_rd_valid && !re_prot[blk_of(i_rd_addr)];
  wire run_done  = busy && o_us_tick && us_left == 18'h00001;

  // ----------------------------------------------------------------
  // protection registers and tick divider
  // ----------------------------------------------------------------
  fpec_prot u_prot
  (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_nv_re   (i_nv_re),
    .i_nv_pe   (i_nv_pe),
    .i_wr_re   (i_bus.wr && hit_re),
    .i_wr_pe   (i_bus.wr && hit_pe),
    .i_wdata   (i_bus.wdata[7:0]),
    .o_re      (re_prot),
    .o_pe      (pe_prot)
  );

  // R10: tick reload drives the divider
  fpec_tick u_tick
  (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_run     (busy),
    .i_reload  (tick_reload),
    .o_tick    (o_us_tick)
  );

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // R25: tick reload reset value
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      target      <= 13'h0000;
      wdata       <= 32'h0000_0000;
      tick_reload <= `FPEC_TICK_RESET;
      irq_mask    <= 8'h00;
    end
    else if (i_bus.wr)
    begin
      // R12: offset field 12:0
      if (hit_target)
        target <= i_bus.wdata[12:0];
      if (hit_wdata)
        wdata <= i_bus.wdata;
      if (hit_tick)
        tick_reload <= i_bus.wdata[7:0];
      if (hit_mask)
        irq_mask <= {6'h00, i_bus.wdata[1:0]};
    end
  end

  // ----------------------------------------------------------------
  // raw status, set wins over clear
  // ----------------------------------------------------------------
  wire       prog_set = run_done && op != fpec_pkg::op_commit;
  wire       acc_set  = cmd_viol || o_rd_blocked;
  // R19: write one to clear
  wire [1:0] raw_clr  = (i_bus.wr && hit_misc) ? i_bus.wdata[1:0] : 2'b00;
  wire [1:0] raw_set;
  // R23: completion and violation flags
  assign raw_set[`FPEC_RAW_PROG] = prog_set;
  assign raw_set[`FPEC_RAW_ACC]  = acc_set;
  wire [1:0] next_raw = (raw & ~raw_clr) | raw_set;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      raw <= 2'b00;
    else
      raw <= next_raw;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state   <= fpec_pkg::st_idle;
      op      <= fpec_pkg::op_none;
      us_left <= 18'h00000;
    end
    else
    begin
      unique case (state)
        fpec_pkg::st_idle:
          // R14: start at held offset
          if (start)
          begin
            state   <= fpec_pkg::st_run;
            op      <= req_op;
            us_left <= us_len(req_op);
          end
        fpec_pkg::st_run:
          // R20: pulse lasts its tick count
          if (run_done)
          begin
            state <= fpec_pkg::st_idle;
            op    <= fpec_pkg::op_none;
          end
          else if (o_us_tick)
            us_left <= us_left - 18'h00001;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array request
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_nvm <= '0;
    else if (start)
    begin
      o_nvm.active <= 1'b1;
      o_nvm.kind   <= req_op;
      // R1: commit target select
      o_nvm.commit_pe <= target[0];
      o_nvm.offset    <= target;
      // R2: commit carries selected value
      // R13: data only for program
      unique case (req_op)
        fpec_pkg::op_write:
          o_nvm.data <= wdata;
        fpec_pkg::op_commit:
          o_nvm.data <= {24'h000000, target[0] ? pe_prot : re_prot};
        default:
          o_nvm.data <= 32'h0000_0000;
      endcase
    end
    else if (run_done)
      o_nvm <= '0;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // R16: key reads as zero
  // R17: busy bits read back
  // R21: write bit reads one until done
  wire [31:0] cmd_rd = {28'h0000000,
                        op == fpec_pkg::op_commit,
                        op == fpec_pkg::op_full_erase_bit,
                        op == fpec_pkg::op_erase,
                        op == fpec_pkg::op_write};
  // R8: upper protection bits read zero
  wire [31:0] rd_mux =
    hit_target ? {19'h00000, target}        :
    hit_wdata  ? wdata                      :
    hit_cmd    ? cmd_rd                     :
    hit_raw    ? {30'h00000000, raw}        :
    hit_mask   ? {24'h000000, irq_mask}     :
    hit_misc   ? {30'h00000000, raw & irq_mask[1:0]} :
    hit_re     ? {24'h000000, re_prot}      :
    hit_pe     ? {24'h000000, pe_prot}      :
    hit_tick   ? {24'h000000, tick_reload}  :
                 32'h0000_0000;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= 32'h0000_0000;
    else if (i_bus.rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_bad_key;
    cmd_wr && !key_ok && !busy |=> !busy;
  endproperty
  a_bad_key: assert property (p_bad_key) // R16
    else $error("unkeyed command started an operation");
  property p_start_write;
    cmd_take && req_op == fpec_pkg::op_write && tgt_pe_ok
      |=> busy && op == fpec_pkg::op_write && o_nvm.active
          && o_nvm.data == $past(wdata);
  endproperty
  a_start_write: assert property (p_start_write) // R14
    else $error("keyed write did not start program");
  property p_busy_ignore;
    busy && cmd_wr && !run_done |=> op == $past(op);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) // R24
    else $error("command accepted while busy");
  property p_write_reads_busy;
    i_bus.rd && hit_cmd && op == fpec_pkg::op_write |=> o_rdata[0];
  endproperty
  a_write_reads_busy: assert property (p_write_reads_busy) // R21
    else $error("write bit not read as one while busy");
  property p_key_zero;
    i_bus.rd && hit_cmd |=> o_rdata[31:16] == 16'h0000;
  endproperty
  a_key_zero: assert property (p_key_zero) // R16
    else $error("key field read nonzero");
  property p_done_flag;
    run_done && op != fpec_pkg::op_commit
      |=> raw[`FPEC_RAW_PROG] && !busy;
  endproperty
  a_done_flag: assert property (p_done_flag) // R23
    else $error("completion flag not set");
  property p_pe_block;
    cmd_take && req_op == fpec_pkg::op_erase && !tgt_pe_ok
      |=> !busy && raw[`FPEC_RAW_ACC];
  endproperty
  a_pe_block: assert property (p_pe_block) // R22
    else $error("erase of protected block not refused");
  property p_w1c;
    i_bus.wr && hit_misc && i_bus.wdata[1] && !prog_set
      |=> !raw[`FPEC_RAW_PROG];
  endproperty
  a_w1c: assert property (p_w1c) // R19
    else $error("write one did not clear status");
  property p_commit_len;
    start && req_op == fpec_pkg::op_commit
      |=> busy && us_left == 18'(P_COMMIT_US) && o_nvm.commit_pe
          == $past(target[0]);
  endproperty
  a_commit_len: assert property (p_commit_len) // R17
    else $error("commit not started with its length");

  c_write: cover property (start && req_op == fpec_pkg::op_write);
  c_erase: cover property (start && req_op == fpec_pkg::op_erase);
  c_commit: cover property (start && req_op == fpec_pkg::op_commit);
  c_rd_block: cover property (o_rd_blocked);

endmodule

// *** core/fpec_params.svh ***
`ifndef FPEC_PARAMS_SVH
`define FPEC_PARAMS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define FPEC_FLASH_BASE   32'h400F_D000
`define FPEC_SYSCTL_BASE  32'h400F_E000
`define FPEC_OFS_TARGET   12'h000
`define FPEC_OFS_WDATA    12'h004
`define FPEC_OFS_CMD      12'h008
`define FPEC_OFS_RAW      12'h00C
`define FPEC_OFS_MASK     12'h010
`define FPEC_OFS_MISC     12'h014
`define FPEC_OFS_RE_PROT  12'h130
`define FPEC_OFS_PE_PROT  12'h134
`define FPEC_OFS_TICK     12'h140

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FPEC_CMD_KEY      16'hA442
`define FPEC_CMD_WRITE    0
`define FPEC_CMD_ERASE    1
`define FPEC_CMD_FULL_ERASE_BIT   2
`define FPEC_CMD_COMMIT   3
`define FPEC_RAW_ACC      0
`define FPEC_RAW_PROG     1
`define FPEC_PROT_RESET   8'hFF
`define FPEC_TICK_RESET   8'h18

// ----------------------------------------------------------------
// pulse lengths in microsecond ticks
// ----------------------------------------------------------------
`define FPEC_PROG_US      50
`define FPEC_COMMIT_US    50
`define FPEC_ERASE_US     25000
`define FPEC_FULL_ERASE_BIT_US    250000

`endif

// *** core/fpec_pkg.sv ***
package fpec_pkg;

  typedef enum logic [2:0]
  {
    op_none,
    op_write,
    op_erase,
    op_full_erase_bit,
    op_commit
  } fpec_op_e;

  typedef enum logic
  {
    st_idle,
    st_run
  } fpec_state_e;

  // register port request
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpec_bus_s;

  // operation presented to the array
  typedef struct packed
  {
    logic        active;
    fpec_op_e    kind;
    logic        commit_pe;
    logic [12:0] offset;
    logic [31:0] data;
  } fpec_nvm_s;

endpackage

// *** core/fpec_prot.sv ***
`timescale 1ns/10ps
`include "fpec_params.svh"

// ----------------------------------------------------------------
// block protection registers, clear-only, reloaded after reset
// ----------------------------------------------------------------
module fpec_prot
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_nv_re,
  input  wire logic [7:0] i_nv_pe,
  input  wire logic       i_wr_re,
  input  wire logic       i_wr_pe,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_re,
  output logic      [7:0] o_pe
);

  logic loaded;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      loaded <= 1'b0;
    else
      loaded <= 1'b1;
  end

  // R7: reload committed values
  // R6: writes only clear bits
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_re <= `FPEC_PROT_RESET;
      o_pe <= `FPEC_PROT_RESET;
    end
    else if (!loaded)
    begin
      o_re <= i_nv_re;
      o_pe <= i_nv_pe;
    end
    else
    begin
      if (i_wr_re)
        o_re <= o_re & i_wdata;
      if (i_wr_pe)
        o_pe <= o_pe & i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // R6: writes never set
  property p_prot_clear_only;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      loaded && i_wr_pe |=> (o_pe & ~$past(o_pe)) == 8'h00;
  endproperty
  a_prot_clear_only: assert property (p_prot_clear_only) // R6
    else $error("protection bit set by write");
  property p_re_clear_only;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      loaded && i_wr_re |=> (o_re & ~$past(o_re)) == 8'h00;
  endproperty
  a_re_clear_only: assert property (p_re_clear_only) // R6
    else $error("read enable bit set by write");

endmodule

// *** core/fpec_tick.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// microsecond tick divider
// ----------------------------------------------------------------
module fpec_tick
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_run,
  input  wire logic [7:0] i_reload,
  output logic            o_tick
);

  logic [7:0] count;

  assign o_tick = i_run && (count == 8'h00);

  // restart the divider whenever idle so each pulse starts clean
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      count <= 8'h00;
    else if (!i_run || count == 8'h00)
      count <= i_reload;
    else
      count <= count - 8'h01;
  end

endmodule

// *** verif/fpec_flash_model.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// nonvolatile protection store
// ----------------------------------------------------------------
module fpec_flash_model
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset_n,
  input  wire fpec_pkg::fpec_nvm_s i_nvm,
  output logic               [7:0] o_nv_re,
  output logic               [7:0] o_nv_pe
);
  logic       pend;
  logic       pend_pe;
  logic [7:0] pend_val;

  initial
  begin
    pend    = 1'b0;
    o_nv_re = 8'hFF;
    o_nv_pe = 8'hFF;
    forever
    begin
      @(posedge i_ref_clk);
      if (!i_reset_n)
        pend <= 1'b0;
      else if (i_nvm.active && i_nvm.kind == fpec_pkg::op_commit)
      begin
        pend     <= 1'b1;
        pend_pe  <= i_nvm.commit_pe;
        pend_val <= i_nvm.data[7:0];
      end
      else if (pend)
      begin
        pend <= 1'b0;
        if (pend_pe)
          o_nv_pe <= pend_val;
        else
          o_nv_re <= pend_val;
      end
    end
  end
endmodule

// *** verif/test_flash_program_erase_controller.sv ***
`timescale 1ns/10ps
`include "fpec_params.svh"

module test_flash_program_erase_controller;
  logic                i_ref_clk;
  logic                i_reset_n;
  fpec_pkg::fpec_bus_s bus;
  logic         [31:0] rdata;
  logic          [7:0] nv_re;
  logic          [7:0] nv_pe;
  logic                rd_valid;
  logic         [13:0] rd_addr;
  logic                rd_blocked;
  fpec_pkg::fpec_nvm_s nvm;
  logic                us_tick;
  int                  fails;
  int                  check_count;
  int                  cycles;
  int                  n;
  int                  blk;
  int                  blk2;
  logic         [12:0] offs;
  logic         [31:0] data;
  logic          [7:0] rl;
  logic          [7:0] pe_val;
  logic          [7:0] re_val;

  fpec_ctrl
  #(
    .P_PROG_US   (3),
    .P_COMMIT_US (3),
    .P_ERASE_US  (4),
    .P_FULL_ERASE_BIT_US (6)
  )
  i_dut
  (
    .i_ref_clk    (i_ref_clk),
    .i_reset_n    (i_reset_n),
    .i_bus        (bus),
    .o_rdata      (rdata),
    .i_nv_re      (nv_re),
    .i_nv_pe      (nv_pe),
    .i_rd_valid   (rd_valid),
    .i_rd_addr    (rd_addr),
    .o_rd_blocked (rd_blocked),
    .o_nvm        (nvm),
    .o_us_tick    (us_tick)
  );

  fpec_flash_model i_nvm
  (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_nvm     (nvm),
    .o_nv_re   (nv_re),
    .o_nv_pe   (nv_pe)
  );

  always #4 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] fa(input logic [11:0] o);
    return `FPEC_FLASH_BASE + {20'h0, o};
  endfunction

  function automatic logic [31:0] sa(input logic [11:0] o);
    return `FPEC_SYSCTL_BASE + {20'h0, o};
  endfunction

  function automatic logic [31:0] cmd_word(input int b);
    return {`FPEC_CMD_KEY, 12'h000, 4'(1 << b)};
  endfunction

  function automatic fpec_pkg::fpec_op_e op_of(input int b);
    return fpec_pkg::fpec_op_e'(b + 1);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp,
                       input string nm);
    @(posedge i_ref_clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  task automatic start_op(input int b, input logic [12:0] o,
                          input logic [31:0] d);
    bus_wr(fa(`FPEC_OFS_WDATA), d);
    bus_wr(fa(`FPEC_OFS_TARGET), {19'h0, o});
    bus_wr(fa(`FPEC_OFS_CMD), cmd_word(b));
    step();
  endtask

  task automatic wait_idle();
    n = 0;
    while (nvm.active === 1'b1 && n < 2000)
    begin
      step();
      n++;
    end
    chk("op end", 32'(nvm.active), 32'h0);
  endtask

  task automatic do_reset();
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic commit(input logic sel, input logic [7:0] val);
    start_op(3, 13'(sel), $urandom);
    chk("commit kind", 32'(nvm.kind), 32'(fpec_pkg::op_commit));
    chk("commit target", 32'(nvm.commit_pe), 32'(sel));
    chk("commit value", 32'(nvm.data[7:0]), 32'(val));
    rdchk(fa(`FPEC_OFS_CMD), 32'h8, "commit busy");
    wait_idle();
    rdchk(fa(`FPEC_OFS_CMD), 32'h0, "commit done");
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      $display("MISMATCH timeout expected done seen running");
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_ref_clk   = 1'b0;
    i_reset_n   = 1'b0;
    bus         = '0;
    rd_valid    = 1'b0;
    rd_addr     = '0;
    fails       = 0;
    check_count = 0;
    cycles      = 0;
    void'($urandom(76));
    do_reset();
    for (int i = 0; i < 7; i++)
      rdchk(fa(12'(i * 4)), 32'h0, "flash reset");
    rdchk(sa(`FPEC_OFS_RE_PROT), 32'hFF, "re reset");
    rdchk(sa(`FPEC_OFS_PE_PROT), 32'hFF, "pe reset");
    rdchk(sa(`FPEC_OFS_TICK), 32'h18, "tick reset");
    rl = 8'(6 + $urandom_range(4));
    bus_wr(sa(`FPEC_OFS_TICK), {24'h0, rl});
    rdchk(sa(`FPEC_OFS_TICK), {24'h0, rl}, "tick reload");
    for (int b = 0; b < 3; b++)
    begin
      offs = 13'($urandom) & ((b == 1) ? 13'h1C00 : 13'h1FFC);
      data = $urandom;
      start_op(b, offs, data);
      if (b == 0)
      begin
        while (us_tick !== 1'b1 && n < 50)
        begin
          step();
          n++;
        end
        n = 0;
        do
        begin
          step();
          n++;
        end
        while (us_tick !== 1'b1 && n < 50);
        chk("tick gap", n, 32'(rl) + 1);
        chk("op data", nvm.data, data);
      end
      chk("op kind", 32'(nvm.kind), 32'(op_of(b)));
      chk("op offset", 32'(nvm.offset), 32'(offs));
      rdchk(fa(`FPEC_OFS_CMD), 32'(1 << b), "busy bit");
      bus_wr(fa(`FPEC_OFS_CMD), cmd_word(3));
      step();
      chk("busy refusal", 32'(nvm.kind), 32'(op_of(b)));
      wait_idle();
      rdchk(fa(`FPEC_OFS_CMD), 32'h0, "busy clear");
      rdchk(fa(`FPEC_OFS_RAW), 32'h2, "done flag");
    end
    bus_wr(fa(`FPEC_OFS_CMD), 32'hA443_0002);
    step();
    chk("bad key", 32'(nvm.active), 32'h0);
    bus_wr(fa(`FPEC_OFS_MASK), 32'h3);
    rdchk(fa(`FPEC_OFS_MISC), 32'h2, "masked");
    bus_wr(fa(`FPEC_OFS_MISC), 32'h2);
    rdchk(fa(`FPEC_OFS_RAW), 32'h0, "raw clear");
    blk    = $urandom_range(3);
    pe_val = ~(8'h01 << blk);
    bus_wr(sa(`FPEC_OFS_PE_PROT), {24'hFFFFFF, pe_val});
    bus_wr(sa(`FPEC_OFS_PE_PROT), 32'hFFFF_FFFF);
    rdchk(sa(`FPEC_OFS_PE_PROT), {24'h0, pe_val}, "clear only");
    start_op(1, 13'(blk << 11), 32'h0);
    chk("guarded erase", 32'(nvm.active), 32'h0);
    rdchk(fa(`FPEC_OFS_RAW), 32'h1, "access flag");
    blk2   = $urandom_range(7);
    re_val = ~(8'h01 << blk2);
    bus_wr(sa(`FPEC_OFS_RE_PROT), {24'h0, re_val});
    rd_valid <= 1'b1;
    rd_addr  <= {3'(blk2), 11'($urandom)};
    step();
    chk("read blocked", 32'(rd_blocked), 32'h1);
    @(posedge i_ref_clk);
    rd_addr <= {3'(blk2 ^ 1), 11'h0};
    step();
    chk("read open", 32'(rd_blocked), 32'h0);
    @(posedge i_ref_clk);
    rd_valid <= 1'b0;
    commit(1'b1, pe_val);
    do_reset();
    rdchk(sa(`FPEC_OFS_PE_PROT), {24'h0, pe_val}, "pe kept");
    rdchk(sa(`FPEC_OFS_RE_PROT), 32'hFF, "re restored");
    bus_wr(sa(`FPEC_OFS_RE_PROT), {24'h0, re_val});
    commit(1'b0, re_val);
    do_reset();
    rdchk(sa(`FPEC_OFS_RE_PROT), {24'h0, re_val}, "re kept");
    tally_and_finish();
  end
endmodule
